// File: common/socr_pkg.sv
/*
 Constants, types and decode helpers shared by the output synthesizer
 configuration register slice. Assumes an AHB-Lite register bus with
 32-bit data; each byte register sits in the low lane of one word.
*/

package socr_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_PULSE_LOW  = 8'h45;
   localparam logic [7:0] IDX_PULSE_MID  = 8'h46;
   localparam logic [7:0] IDX_PULSE_HIGH = 8'h47;
   localparam logic [7:0] IDX_ENABLE     = 8'h48;
   localparam logic [7:0] IDX_RUN        = 8'h49;
   localparam logic [7:0] IDX_MULT_LOW   = 8'h4a;
   localparam logic [7:0] IDX_MULT_HIGH  = 8'h4b;
   localparam logic [7:0] IDX_QUADRANT   = 8'h4c;
   localparam logic [7:0] IDX_STATUS     = 8'h60;
   localparam int unsigned NUM_REGS      = 8;

   // Reset values, slot 0 (index 0x45) in the low byte
   localparam logic [7:0] RST_PULSE_LOW  = 8'h00;
   localparam logic [7:0] RST_PULSE_MID  = 8'h00;
   localparam logic [7:0] RST_PULSE_HIGH = 8'h00;
   localparam logic [7:0] RST_ENABLE     = 8'h8f;
   localparam logic [7:0] RST_RUN        = 8'h0f;
   localparam logic [7:0] RST_MULT_LOW   = 8'hc1;
   localparam logic [7:0] RST_MULT_HIGH  = 8'h00;
   localparam logic [7:0] RST_QUADRANT   = 8'h00;
   localparam logic [63:0] RST_PACKED = {RST_QUADRANT, RST_MULT_HIGH,
      RST_MULT_LOW, RST_RUN, RST_ENABLE, RST_PULSE_HIGH, RST_PULSE_MID,
      RST_PULSE_LOW};

   // Field positions
   localparam int unsigned BIT_CLK_A      = 0;
   localparam int unsigned BIT_CLK_B      = 1;
   localparam int unsigned BIT_LOOP_SEL   = 6;
   localparam int unsigned COARSE_MSB     = 5;
   localparam int unsigned MULT_HIGH_MSB  = 5;
   localparam int unsigned QUAD_MSB       = 1;

   // Units of the programmed values
   localparam int unsigned FINE_STEP_KHZ  = 262144;  // 262.144 MHz period
   localparam int unsigned COARSE_STEP_HZ = 8000;
   localparam int unsigned MULT_STEP_HZ   = 8000;
   localparam int unsigned CLK_HZ         = 25000000;

   ////////////////////////////////////////////////////////////////////////
   // Decoded transfer of one address phase
   typedef struct packed {
      logic       valid;
      logic       write;
      logic       in_map;
      logic [7:0] idx;
   } socr_xfer_t;

   // Settings handed to the synthesizer core
   typedef struct packed {
      logic [21:0] pulse_offset;
      logic        loop_select;
      logic [13:0] mult;
      logic [1:0]  quadrant;
   } socr_synth_cfg_t;

   // Per-pin control
   typedef struct packed {
      logic drive_enable;
      logic toggle;
   } socr_pin_ctl_t;

   // Index belongs to the byte register bank
   function automatic logic is_cfg(input logic [7:0] idx);
      return (idx >= IDX_PULSE_LOW) && (idx <= IDX_QUADRANT);
   endfunction

   // Slot within the bank
   function automatic logic [2:0] slot_of(input logic [7:0] idx);
      logic [7:0] diff;
      diff = idx - IDX_PULSE_LOW;
      return diff[2:0];
   endfunction

endpackage

// File: design/socr_addr_capture.sv
/*
 AHB-Lite address phase decoder and data phase holder.
 Assumes a single slave whose hreadyout is the bus hready.
*/
`timescale 1ns/1ps
`default_nettype none

module socr_addr_capture
(
   // Clock and reset
   input  wire  logic               hclk,
   input  wire  logic               hresetn,
   // Address phase
   input  wire  logic               hsel,
   input  wire  logic [31:0]        haddr,
   input  wire  logic [1:0]         htrans,
   input  wire  logic               hwrite,
   input  wire  logic               hready,
   // Decoded phases
   output var   socr_pkg::socr_xfer_t addr_now,
   output var   socr_pkg::socr_xfer_t xfer_reg
);

   ////////////////////////////////////////////////////////////////////////
   // Only NONSEQ/SEQ with hready start a transfer; upper bits must be zero
   wire logic       start    = hsel & htrans[1] & hready;
   wire logic       word_ok  = (haddr[31:10] == 22'h0) &
                               (haddr[1:0] == 2'h0);
   wire logic [7:0] idx      = haddr[9:2];

   assign addr_now.valid  = start;
   assign addr_now.write  = hwrite;
   assign addr_now.in_map = word_ok;
   assign addr_now.idx    = idx;

   // Held for the data phase; zero wait states so one cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         xfer_reg <= '0;
      else if (hready)
         xfer_reg <= addr_now;
   end

endmodule

`default_nettype wire

// File: design/socr_pin_stage.sv
/*
 Output stage of one synthesizer clock pin: gates the toggle and drives
 the enable. Assumes the raw clock is synchronous to hclk.
*/
`timescale 1ns/1ps
`default_nettype none

module socr_pin_stage
(
   // Clock and reset
   input  wire  logic                  hclk,
   input  wire  logic                  hresetn,
   // Control and raw clock
   input  wire  socr_pkg::socr_pin_ctl_t ctl,
   input  wire  logic                  raw_clock,
   // Pin
   output logic                        pin_out,
   output logic                        pin_oe
);

   ////////////////////////////////////////////////////////////////////////
   // Stopped clock parks low so restart begins on a clean rising edge
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end
      else
      begin
         pin_out <= ctl.toggle & raw_clock;
         pin_oe  <= ctl.drive_enable;
      end
   end

endmodule

`default_nettype wire

// File: design/socr_regs.sv
/*
 Configuration register slice for the second output synthesizer and the
 three offset bytes of the first synthesizer's second frame pulse.
 Assumes an AHB-Lite master doing single word transfers, raw clocks from
 the synthesizer core synchronous to hclk.
*/
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module socr_regs
(
   // Clock and reset
   input  wire  logic                    hclk,
   input  wire  logic                    hresetn,
   // AHB-Lite slave
   input  wire  logic                    hsel,
   input  wire  logic [31:0]             haddr,
   input  wire  logic [1:0]              htrans,
   input  wire  logic                    hwrite,
   input  wire  logic [2:0]              hsize,
   input  wire  logic [31:0]             hwdata,
   input  wire  logic                    hready,
   output logic                          hreadyout,
   output logic                          hresp,
   output logic [31:0]                   hrdata,
   // Raw synthesizer clocks
   input  wire  logic                    synth_clock_a_raw,
   input  wire  logic                    synth_clock_b_raw,
   // Synthesizer settings
   output var   socr_pkg::socr_synth_cfg_t cfg_reg,
   // Clock pins
   output logic                          second_synth_clock_a,
   output logic                          second_synth_clock_a_oe,
   output logic                          second_synth_clock_b,
   output logic                          second_synth_clock_b_oe
);

   ////////////////////////////////////////////////////////////////////////
   // Bus front end
   socr_pkg::socr_xfer_t addr_now;
   socr_pkg::socr_xfer_t xfer_reg;

   socr_addr_capture u_capture
   (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .hsel     (hsel),
      .haddr    (haddr),
      .htrans   (htrans),
      .hwrite   (hwrite),
      .hready   (hready),
      .addr_now (addr_now),
      .xfer_reg (xfer_reg)
   );

   // hsize is not decoded: every access acts on the low byte lane
   wire logic unused_size = ^hsize;

   ////////////////////////////////////////////////////////////////////////
   // Byte register bank
   logic [7:0] regs_reg  [socr_pkg::NUM_REGS];
   logic [7:0] regs_next [socr_pkg::NUM_REGS];

   wire logic       wr_fire = xfer_reg.valid & xfer_reg.write &
                              xfer_reg.in_map &
                              socr_pkg::is_cfg(xfer_reg.idx);
   wire logic [2:0] wr_slot = socr_pkg::slot_of(xfer_reg.idx);

   // Reserved bits are stored as written and read back unchanged
   always_comb
   begin
      for (int i = 0; i < socr_pkg::NUM_REGS; i++)
      begin
         regs_next[i] = regs_reg[i];
      end
      if (wr_fire)
         regs_next[wr_slot] = hwdata[7:0];
   end

   // Write lands at the end of the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < socr_pkg::NUM_REGS; i++)
            regs_reg[i] <= socr_pkg::RST_PACKED[i*8 +: 8];
      end
      else
      begin
         for (int i = 0; i < socr_pkg::NUM_REGS; i++)
            regs_reg[i] <= regs_next[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Named views of the bank
   wire logic [7:0] pulse_b_fine_delay_low =
      regs_reg[socr_pkg::slot_of(socr_pkg::IDX_PULSE_LOW)];
   wire logic [7:0] pulse_b_fine_delay_mid =
      regs_reg[socr_pkg::slot_of(socr_pkg::IDX_PULSE_MID)];
   wire logic [7:0] pulse_high_byte =
      regs_reg[socr_pkg::slot_of(socr_pkg::IDX_PULSE_HIGH)];
   wire logic [7:0] enable_byte =
      regs_reg[socr_pkg::slot_of(socr_pkg::IDX_ENABLE)];
   wire logic [7:0] run_byte =
      regs_reg[socr_pkg::slot_of(socr_pkg::IDX_RUN)];
   wire logic [7:0] clock_a_multiplier_low =
      regs_reg[socr_pkg::slot_of(socr_pkg::IDX_MULT_LOW)];
   wire logic [7:0] mult_high_byte =
      regs_reg[socr_pkg::slot_of(socr_pkg::IDX_MULT_HIGH)];
   wire logic [7:0] quadrant_byte =
      regs_reg[socr_pkg::slot_of(socr_pkg::IDX_QUADRANT)];

   // coarse field, whole 8 kHz cycles
   wire logic [5:0] pulse_b_coarse_delay =
      pulse_high_byte[socr_pkg::COARSE_MSB:0];
   wire logic [5:0] clock_a_multiplier_high =
      mult_high_byte[socr_pkg::MULT_HIGH_MSB:0];
   wire logic [1:0] clock_a_quadrant_shift =
      quadrant_byte[socr_pkg::QUAD_MSB:0];

   ////////////////////////////////////////////////////////////////////////
   // Synthesizer settings; reserved bits never reach the core
   socr_pkg::socr_synth_cfg_t cfg_next;

   // one 22-bit offset from three bytes
   // middle byte, low byte, fine part in 262.144 MHz periods
   assign cfg_next.pulse_offset = {pulse_b_coarse_delay,
                                   pulse_b_fine_delay_mid,
                                   pulse_b_fine_delay_low};
   assign cfg_next.loop_select  = enable_byte[socr_pkg::BIT_LOOP_SEL];
   assign cfg_next.mult         = {clock_a_multiplier_high,
                                   clock_a_multiplier_low};
   assign cfg_next.quadrant     = clock_a_quadrant_shift;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cfg_reg <= '0;
      else
         cfg_reg <= cfg_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock pin control
   socr_pkg::socr_pin_ctl_t ctl_a;
   socr_pkg::socr_pin_ctl_t ctl_b;

   assign ctl_a.drive_enable = enable_byte[socr_pkg::BIT_CLK_A];
   assign ctl_a.toggle       = run_byte[socr_pkg::BIT_CLK_A];
   assign ctl_b.drive_enable = enable_byte[socr_pkg::BIT_CLK_B];
   assign ctl_b.toggle       = run_byte[socr_pkg::BIT_CLK_B];

   socr_pin_stage u_pin_a
   (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .ctl       (ctl_a),
      .raw_clock (synth_clock_a_raw),
      .pin_out   (second_synth_clock_a),
      .pin_oe    (second_synth_clock_a_oe)
   );

   socr_pin_stage u_pin_b
   (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .ctl       (ctl_b),
      .raw_clock (synth_clock_b_raw),
      .pin_out   (second_synth_clock_b),
      .pin_oe    (second_synth_clock_b_oe)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read path; data taken from the bank after any write now landing,
   // so a read right behind a write sees the new value
   wire logic       rd_fire = addr_now.valid & ~addr_now.write &
                              addr_now.in_map;
   wire logic       rd_cfg  = socr_pkg::is_cfg(addr_now.idx);
   wire logic       rd_stat = (addr_now.idx == socr_pkg::IDX_STATUS);
   wire logic [7:0] rd_bank = regs_next[socr_pkg::slot_of(addr_now.idx)];
   wire logic [7:0] status_byte = {4'h0,
                                   second_synth_clock_b_oe,
                                   second_synth_clock_b,
                                   second_synth_clock_a_oe,
                                   second_synth_clock_a};
   wire logic [7:0] rd_byte = rd_cfg  ? rd_bank :
                              rd_stat ? status_byte : 8'h00;
   wire logic [31:0] hrdata_next = rd_fire ? {24'h000000, rd_byte}
                                           : 32'h00000000;

   // Zero wait states, always OKAY
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hrdata    <= hrdata_next;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_write_addr(logic [7:0] idx);
      addr_now.valid && addr_now.write && addr_now.in_map &&
         (addr_now.idx == idx);
   endsequence

   sequence s_write_data;
      ##1 hreadyout;
   endsequence

   a_mid_byte_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_write_addr(socr_pkg::IDX_PULSE_MID) ##0 s_write_data
      |=> pulse_b_fine_delay_mid == $past(hwdata[7:0]))
      else $error("offset middle byte not written");

   a_low_byte_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_write_addr(socr_pkg::IDX_PULSE_LOW) ##0 s_write_data
      |=> ##1 cfg_reg.pulse_offset[7:0] == $past(hwdata[7:0], 2))
      else $error("offset low byte not in cfg");

   a_coarse_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_write_addr(socr_pkg::IDX_PULSE_HIGH) ##0 s_write_data
      |=> ##1 cfg_reg.pulse_offset[21:16] == $past(hwdata[5:0], 2))
      else $error("coarse offset not in cfg");

   // Armed only from an edge that saw reset high, so the release edge,
   // at which the flops still hold their reset values, is not judged
   a_offset_assembled: assert property (
      @(posedge hclk) disable iff (!hresetn)
      hresetn |=> cfg_reg.pulse_offset == $past({pulse_high_byte[5:0],
         pulse_b_fine_delay_mid, pulse_b_fine_delay_low}))
      else $error("offset not assembled from three bytes");

   a_drive_enables: assert property (
      @(posedge hclk) disable iff (!hresetn)
      hresetn |=>
         (second_synth_clock_a_oe == $past(enable_byte[0])) &&
         (second_synth_clock_b_oe == $past(enable_byte[1])))
      else $error("pin enable does not follow register");

   a_clock_a_low: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !run_byte[socr_pkg::BIT_CLK_A] |=> !second_synth_clock_a)
      else $error("stopped clock A not low");

   a_clock_b_low: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !run_byte[socr_pkg::BIT_CLK_B] |=> !second_synth_clock_b)
      else $error("stopped clock B not low");

   a_loop_select: assert property (
      @(posedge hclk) disable iff (!hresetn)
      hresetn |=> cfg_reg.loop_select == $past(enable_byte[6]))
      else $error("loop select mismatch");

   a_multiplier_word: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_write_addr(socr_pkg::IDX_MULT_HIGH) ##0 s_write_data
      |=> ##1 cfg_reg.mult[13:8] == $past(hwdata[5:0], 2))
      else $error("multiplier high bits not written");

   a_quadrant_code: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_write_addr(socr_pkg::IDX_QUADRANT) ##0 s_write_data
      |=> ##1 cfg_reg.quadrant == $past(hwdata[1:0], 2))
      else $error("quadrant code not written");

   // Read returns the bank value including a write just landed
   a_read_data: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_fire && rd_cfg |=> hrdata == {24'h000000, $past(rd_bank)})
      else $error("read data wrong");

endmodule

`default_nettype wire

// File: bench/socr_regs_bench.sv
/*
 Self-checking bench for the synthesizer configuration register slice.
 Assumes hreadyout is fed back as hready, and raw synth clocks are levels
 the bench sets and holds while the pins are sampled.
*/
`timescale 1ns/1ps
`default_nettype none

module socr_regs_bench;
   logic                      hclk;
   logic                      hresetn;
   logic                      hsel;
   logic [31:0]               haddr;
   logic [1:0]                htrans;
   logic                      hwrite;
   logic [2:0]                hsize;
   logic [31:0]               hwdata;
   logic                      hready;
   logic                      hreadyout;
   logic                      hresp;
   logic [31:0]               hrdata;
   logic                      raw_a;
   logic                      raw_b;
   socr_pkg::socr_synth_cfg_t cfg;
   logic                      pin_a;
   logic                      oe_a;
   logic                      pin_b;
   logic                      oe_b;
   int                        failures = 0;
   int                        checks_done = 0;
   int                        cycles = 0;
   logic [31:0]               rd;
   logic [31:0]               v;
   logic [31:0]               addr_junk = 32'h0;
   logic [7:0]                bank [8];
   logic [7:0]                rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h8f,
                                              8'h0f, 8'hc1, 8'h00, 8'h00};
   logic [7:0]                keep_tab [8] = '{8'hff, 8'hff, 8'h3f, 8'h43,
                                               8'h03, 8'hff, 8'h3f, 8'h03};
   logic [7:0]                bad_idx [4] = '{8'h44, 8'h4d, 8'h5f, 8'h00};

   // Single slave: its ready is the bus ready
   assign hready = hreadyout;

   socr_regs DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .synth_clock_a_raw(raw_a),
      .synth_clock_b_raw(raw_b), .cfg_reg(cfg),
      .second_synth_clock_a(pin_a), .second_synth_clock_a_oe(oe_a),
      .second_synth_clock_b(pin_b), .second_synth_clock_b_oe(oe_b));

   ////////////////////////////////////////////////////////////////////////
   // 25 MHz clock
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   // Hang guard, far above the roughly 600 cycles the tests need
   always @(posedge hclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         failures++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         failures++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(string nm, logic e, logic g);
      checks_done++;
      if (g !== e)
      begin
         failures++;
         $display("BAD %s exp %b got %b", nm, e, g);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Expected values from the byte bank model
   function automatic logic [21:0] exp_offset();
      return {bank[2][5:0], bank[1], bank[0]};
   endfunction

   function automatic logic [13:0] exp_mult();
      return {bank[6][5:0], bank[5]};
   endfunction

   // Status byte: pin a, oe a, pin b, oe b from bit 0 up
   function automatic logic [7:0] exp_status(logic ra, logic rb);
      return {4'h0, bank[3][1], bank[4][1] & rb, bank[3][0], bank[4][0] & ra};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // One single transfer; called and left right after a rising edge.
   // Ready and read data are sampled at the falling edge before the edge
   // that takes them, where they are settled. No wait limit of its own:
   // the hang guard ends a stuck run.
   task automatic bus(input logic wr, input logic [7:0] idx,
                      input logic [31:0] wd, output logic [31:0] rdv);
      logic rdy;
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {22'h0, idx, 2'b00} | addr_junk;
      hwrite <= wr;
      do
      begin
         @(negedge hclk);
         rdy = hready;
         @(posedge hclk);
      end while (rdy !== 1'b1);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= wd;
      do
      begin
         @(negedge hclk);
         rdy = hready;
         rdv = hrdata;
         @(posedge hclk);
      end while (rdy !== 1'b1);
      chk_bit("hresp", 1'b0, hresp);
   endtask

   task automatic wr_slot(int i, logic [31:0] w);
      logic [31:0] r;
      bank[i] = (w[7:0] & keep_tab[i]) | (rst_tab[i] & ~keep_tab[i]);
      bus(1'b1, 8'h45 + i[7:0], {w[31:8], bank[i]}, r);
   endtask

   // One extra edge: a write landing at the last edge reaches cfg later
   task automatic check_cfg();
      @(posedge hclk);
      @(negedge hclk);
      chk_word("offset", {10'h0, exp_offset()},
               {10'h0, cfg.pulse_offset});
      chk_word("mult", {18'h0, exp_mult()}, {18'h0, cfg.mult});
      chk_bit("loop", bank[3][6], cfg.loop_select);
      chk_word("quad", {30'h0, bank[7][1:0]}, {30'h0, cfg.quadrant});
      @(posedge hclk);
   endtask

   task automatic check_all();
      logic [31:0] r;
      for (int i = 0; i < 8; i++)
      begin
         bus(1'b0, 8'h45 + i[7:0], 32'h0, r);
         chk_word("register", {24'h0, bank[i]}, r);
      end
      check_cfg();
   endtask

   task automatic check_pins();
      logic [31:0] r;
      logic        ra;
      logic        rb;
      r = $urandom;
      ra = r[0];
      rb = r[1];
      raw_a <= ra;
      raw_b <= rb;
      repeat (3) @(posedge hclk);
      @(negedge hclk);
      chk_bit("oe a", bank[3][0], oe_a);
      chk_bit("oe b", bank[3][1], oe_b);
      chk_bit("pin a", bank[4][0] & ra, pin_a);
      chk_bit("pin b", bank[4][1] & rb, pin_b);
      @(posedge hclk);
      bus(1'b0, 8'h60, 32'h0, r);
      chk_word("status", {24'h0, exp_status(ra, rb)}, r);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      raw_a = 1'b0;
      raw_b = 1'b0;
      void'($urandom(32'hc83f1344));
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bank = rst_tab;
      check_all();
      check_pins();
      $display("test reset values done");
      // Random bytes, then all-ones and all-zeros corners
      repeat (6)
      begin
         for (int i = 0; i < 8; i++)
            wr_slot(i, $urandom);
         check_all();
      end
      for (int i = 0; i < 8; i++)
         wr_slot(i, 32'hffffffff);
      check_all();
      for (int i = 0; i < 8; i++)
         wr_slot(i, 32'h0);
      check_all();
      $display("test register access done");
      // Every enable/run pairing; quadrant codes and loop select sweep too
      for (int m = 0; m < 16; m++)
      begin
         v = $urandom;
         v[1:0] = m[1:0];
         v[6] = m[2];
         wr_slot(3, v);
         v = $urandom;
         v[1:0] = m[3:2];
         wr_slot(4, v);
         wr_slot(7, m);
         check_cfg();
         check_pins();
      end
      $display("test pin control done");
      // Unmapped places read zero and swallow writes
      for (int k = 0; k < 4; k++)
      begin
         bus(1'b1, bad_idx[k], $urandom, rd);
         bus(1'b0, bad_idx[k], 32'h0, rd);
         chk_word("unmapped", 32'h0, rd);
      end
      // Out-of-range and misaligned forms of a mapped index
      for (int k = 0; k < 2; k++)
      begin
         addr_junk = k ? 32'h00000002 : 32'h80000000;
         bus(1'b1, 8'h45, $urandom, rd);
         bus(1'b0, 8'h45, 32'h0, rd);
         addr_junk = 32'h0;
         chk_word("aliased", 32'h0, rd);
      end
      check_all();
      $display("test unmapped access done");
      // Reset in mid run restores the table
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bank = rst_tab;
      check_all();
      check_pins();
      $display("test second reset done");
      give_verdict();
   end
endmodule

`default_nettype wire
